//--- logic/dram_mode_regs.sv
// dram end: mode registers two and three and their effects
module dram_mode_regs
  import mode_reg_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset_n,
  input  wire logic       i_clk_en,
  mode_reg_if.dev         link,
  input  wire logic [2:0] i_additive_latency,
  input  wire logic       i_write_leveling,
  input  wire logic       i_rtt_nom_en,
  input  wire logic       i_write_burst,
  input  wire logic       i_self_refresh,
  input  wire logic       i_read_cmd,
  input  wire logic [7:0] i_array_data,
  output logic      [3:0] o_write_column_latency,
  output logic      [4:0] o_total_write_latency,
  output logic      [1:0] o_rtt_write_sel,
  output logic            o_rtt_nom_only,
  output logic      [2:0] o_partial_array_self_refresh,
  output logic            o_partial_array_lost,
  output logic      [1:0] o_self_refresh_rate,
  output logic            o_calibration_pattern_readout,
  output logic      [1:0] o_cal_location
);
  logic [12:0] wl_reg_q;
  logic [12:0] cal_reg_q;
  logic [7:0]  rd_data_q;
  logic        rd_valid_q;
  logic        rst_n;

  // device reset pin acts alongside the system reset, even in pattern mode
  assign rst_n = i_reset_n & link.reset_n;

  // mode-register-set decode by bank
  wire mrs_cmd = ~link.cs_n & ~link.ras_n & ~link.cas_n & ~link.we_n;
  wire ld_wl   = i_clk_en & mrs_cmd & (link.bank == BANK_WL_REG);
  wire ld_cal  = i_clk_en & mrs_cmd & (link.bank == BANK_CAL_REG);

  // registers hold until their own mrs; reserved bits stored as zero
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wl_reg_q  <= WL_REG_RESET;
      cal_reg_q <= CAL_REG_RESET;
    end else begin
      if (ld_wl) wl_reg_q <= link.addr & WL_REG_KEEP;
      if (ld_cal) cal_reg_q <= link.addr & CAL_REG_KEEP;
    end
  end

  // latency fields
  wire [CWL_W-1:0] cwl_field = wl_reg_q[CWL_LSB +: CWL_W];
  assign o_write_column_latency = {1'b0, cwl_field} + {1'b0, CWL_BASE};
  assign o_total_write_latency  = {2'b00, i_additive_latency} + {1'b0, o_write_column_latency};

  // termination selection
  wire [RTTWR_W-1:0] rtt_field = wl_reg_q[RTTWR_LSB +: RTTWR_W];
  assign o_rtt_nom_only  = i_write_leveling | ~i_write_burst | (rtt_field == RTTWR_OFF);
  assign o_rtt_write_sel = (i_write_leveling | ~i_write_burst) ? RTTWR_OFF : rtt_field;

  // self refresh behaviour
  assign o_partial_array_self_refresh = wl_reg_q[PARTIAL_ARRAY_SELF_REFRESH_LSB +: PARTIAL_ARRAY_SELF_REFRESH_W];
  assign o_partial_array_lost = i_self_refresh & (o_partial_array_self_refresh != 3'h0);
  assign o_self_refresh_rate  = wl_reg_q[SRT_BIT] ? SR_RATE_2X : SR_RATE_1X;

  // pattern readout control; location gated to zero when disabled
  assign o_calibration_pattern_readout = cal_reg_q[CAL_EN_BIT];
  assign o_cal_location = o_calibration_pattern_readout ? cal_reg_q[CAL_LOC_LSB +: CAL_LOC_W] : 2'h0;
  wire [7:0] rd_src = o_calibration_pattern_readout ? CAL_PATTERN : i_array_data;

  // registered read return
  always_ff @(posedge i_sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q  <= 8'h00;
      rd_valid_q <= 1'b0;
    end else if (i_clk_en) begin
      rd_valid_q <= i_read_cmd;
      if (i_read_cmd) rd_data_q <= rd_src;
    end
  end

  assign link.rd_data  = rd_data_q;
  assign link.rd_valid = rd_valid_q;
endmodule

//--- logic/mode_reg_ctl.sv
// controller end: issues mode-register-set commands and paces refresh
//
// The implementer's own choices: the strobed register port and the placing of the registers.
module mode_reg_ctl
  import mode_reg_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_clk_en,
  mode_reg_if.ctl          link,
  input  wire logic        i_wr_en,
  input  wire logic        i_rd_en,
  input  wire logic [1:0]  i_addr,
  input  wire logic [15:0] i_wr_data,
  output logic      [15:0] o_rd_data,
  input  wire logic        i_banks_idle,
  input  wire logic        i_dll_off,
  input  wire logic        i_hot_case,
  input  wire logic        i_dram_reset,
  input  wire logic        i_sr_request,
  output logic             o_sr_enter,
  output logic             o_refresh_tick,
  output logic             o_non_read_allowed
);
  localparam logic [1:0] REG_WL   = 2'h0;
  localparam logic [1:0] REG_CAL  = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  localparam logic [1:0] REG_GO   = 2'h3;

  ctl_state_e        state_q;
  logic [12:0]       wl_q;
  logic [12:0]       cal_q;
  logic              sel_cal_q;
  logic              cal_active_q;
  logic [REFI_W-1:0] refi_q;
  logic [15:0]       rd_q;
  logic [7:0]        last_rd_q;
  logic              busy;
  logic              srt_sent_q;

  // shadow values sanitised so the device only sees legal settings
  wire [12:0] wl_clean  = wl_q & WL_REG_KEEP & (i_dll_off ? ~13'h0600 : 13'h1fff);
  wire [12:0] cal_clean = cal_q & CAL_REG_KEEP;
  wire [12:0] srt_fix   = wl_clean | (i_hot_case ? 13'h0080 : 13'h0000);
  wire        go_cmd    = i_wr_en & (i_addr == REG_GO);
  wire        cal_enabling = i_wr_data[0] & cal_q[CAL_EN_BIT];
  wire        go_ok     = go_cmd & (state_q == ST_IDLE) & (~cal_enabling | i_banks_idle);

  // software shadow registers and sequencer
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wl_q         <= WL_REG_RESET;
      cal_q        <= CAL_REG_RESET;
      sel_cal_q    <= 1'b0;
      state_q      <= ST_IDLE;
      cal_active_q <= 1'b0;
      srt_sent_q   <= 1'b0;
    end else if (i_clk_en) begin
      if (i_wr_en && i_addr == REG_WL) wl_q <= i_wr_data[12:0];
      if (i_wr_en && i_addr == REG_CAL) cal_q <= i_wr_data[12:0];
      case (state_q)
        ST_IDLE: if (go_ok) begin
          sel_cal_q <= i_wr_data[0];
          state_q   <= ST_CMD;
        end
        ST_CMD: begin
          if (sel_cal_q) cal_active_q <= cal_clean[CAL_EN_BIT];
          else srt_sent_q <= srt_fix[SRT_BIT];
          state_q <= ST_DONE;
        end
        ST_DONE: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
      // device reset clears what the device holds, so forget it here too
      if (i_dram_reset) begin
        cal_active_q <= 1'b0;
        srt_sent_q   <= 1'b0;
      end
    end
  end
  assign busy = (state_q != ST_IDLE);

  // command pins driven during the command state
  wire issue = (state_q == ST_CMD);
  assign link.cs_n    = ~issue;
  assign link.ras_n   = ~issue;
  assign link.cas_n   = ~issue;
  assign link.we_n    = ~issue;
  assign link.bank    = sel_cal_q ? BANK_CAL_REG : BANK_WL_REG;
  assign link.addr    = sel_cal_q ? cal_clean : srt_fix;
  assign link.reset_n = ~i_dram_reset;

  // only reads while pattern readout, no self refresh when hot without bit 7
  assign o_non_read_allowed = ~cal_active_q;
  // gate on the rate bit the device really holds, not the pending shadow
  assign o_sr_enter = i_sr_request & ~cal_active_q & (~i_hot_case | srt_sent_q);

  // refresh pacing: interval halved in hot range
  wire [REFI_W-1:0] refi_max = i_hot_case ? REFI_W'(REFI_EXT_CYC - 1) : REFI_W'(REFI_NORM_CYC - 1);
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      refi_q <= '0;
    end else if (i_clk_en) begin
      refi_q <= (refi_q >= refi_max) ? '0 : refi_q + 1'b1;
    end
  end
  assign o_refresh_tick = (refi_q >= refi_max);

  // capture last device read, register read port
  wire [15:0] rd_mux = (i_addr == REG_WL)  ? {3'h0, wl_q} :
                       (i_addr == REG_CAL) ? {3'h0, cal_q} :
                       (i_addr == REG_STAT) ? {last_rd_q, 5'h0, i_hot_case, cal_active_q, busy} : 16'h0000;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_q      <= 16'h0000;
      last_rd_q <= 8'h00;
    end else if (i_clk_en) begin
      if (i_rd_en) rd_q <= rd_mux;
      if (link.rd_valid) last_rd_q <= link.rd_data;
    end
  end
  assign o_rd_data = rd_q;
endmodule

//--- logic/mode_reg_if.sv
// command link between memory controller and dram mode-register logic
interface mode_reg_if;
  import mode_reg_pkg::*;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic              reset_n;
  logic [7:0]        rd_data;
  logic              rd_valid;
  modport ctl (output cs_n, ras_n, cas_n, we_n, bank, addr, reset_n, input rd_data, rd_valid);
  modport dev (input cs_n, ras_n, cas_n, we_n, bank, addr, reset_n, output rd_data, rd_valid);
endinterface

//--- logic/mode_reg_pkg.sv
// shared constants for the mode register two/three link
package mode_reg_pkg;
  localparam int          ADDR_W          = 13;
  localparam int          BANK_W          = 3;
  localparam logic [2:0]  BANK_WL_REG     = 3'h2;
  localparam logic [2:0]  BANK_CAL_REG    = 3'h3;
  // write-latency/refresh register fields
  localparam int          PARTIAL_ARRAY_SELF_REFRESH_LSB        = 0;
  localparam int          PARTIAL_ARRAY_SELF_REFRESH_W          = 3;
  localparam int          CWL_LSB         = 3;
  localparam int          CWL_W           = 3;
  localparam int          SRT_BIT         = 7;
  localparam int          RTTWR_LSB       = 9;
  localparam int          RTTWR_W         = 2;
  localparam logic [12:0] WL_REG_KEEP     = 13'h06ff;  // bits 8,11,12 reserved
  localparam logic [12:0] WL_REG_RESET    = 13'h0000;
  // calibration-pattern register fields
  localparam int          CAL_EN_BIT      = 2;
  localparam int          CAL_LOC_LSB     = 0;
  localparam int          CAL_LOC_W       = 2;
  localparam logic [12:0] CAL_REG_KEEP    = 13'h0007;
  localparam logic [12:0] CAL_REG_RESET   = 13'h0000;
  // encodings
  localparam logic [2:0]  CWL_BASE        = 3'h5;    // field 0 means five clocks
  localparam logic [1:0]  RTTWR_OFF       = 2'h0;
  localparam logic [1:0]  SR_RATE_1X      = 2'h1;
  localparam logic [1:0]  SR_RATE_2X      = 2'h2;
  localparam logic [7:0]  CAL_PATTERN     = 8'h55;   // predefined read pattern
  // refresh interval in ns and in 40 ns clocks, rounded down
  localparam int          CLK_NS          = 40;
  localparam int          REFI_NORM_NS    = 7800;
  localparam int          REFI_EXT_NS     = 3900;
  localparam int          REFI_NORM_CYC   = REFI_NORM_NS / CLK_NS;
  localparam int          REFI_EXT_CYC    = REFI_EXT_NS / CLK_NS;
  localparam int          REFI_W          = 8;
  // controller sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_DONE = 2'b11
  } ctl_state_e;
endpackage

//--- tb/dram_mode_reg_two_three_mpr_tb.sv
// self-checking bench for the mode register two/three link
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module dram_mode_reg_two_three_mpr_tb
  import mode_reg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = '0, rst_n = '0, wr_en = '0, rd_en = '0, idle = '0, dll = '0, hot = '0, drst = '0;
  logic        wlev = '0, burst = '0, sref = '0, rdc = '0, nom, lost, cal, tick, nrd;
  logic        sreq = '1, sren;
  logic [1:0]  addr = '0, rtt, loc, rate;
  logic [2:0]  al = '0, partial_array_self_refresh;
  logic [3:0]  write_column_latency;
  logic [4:0]  wl;
  logic [15:0] wdata = '0, rdata;
  int          bad_count = 0, comparisons = 0, n;
  mode_reg_if link();
  mode_reg_ctl mode_reg_ctl_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .link(link.ctl),
    .i_wr_en(wr_en), .i_rd_en(rd_en), .i_addr(addr), .i_wr_data(wdata), .o_rd_data(rdata), .i_banks_idle(idle),
    .i_dll_off(dll), .i_hot_case(hot), .i_dram_reset(drst), .i_sr_request(sreq), .o_sr_enter(sren),
    .o_refresh_tick(tick), .o_non_read_allowed(nrd));
  dram_mode_regs dram_mode_regs_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .link(link.dev),
    .i_additive_latency(al), .i_write_leveling(wlev), .i_rtt_nom_en(1'b0), .i_write_burst(burst),
    .i_self_refresh(sref), .i_read_cmd(rdc), .i_array_data(8'ha3), .o_write_column_latency(write_column_latency),
    .o_total_write_latency(wl), .o_rtt_write_sel(rtt), .o_rtt_nom_only(nom), .o_partial_array_self_refresh(partial_array_self_refresh),
    .o_partial_array_lost(lost), .o_self_refresh_rate(rate), .o_calibration_pattern_readout(cal),
    .o_cal_location(loc));
  mode_reg_props mode_reg_props_inst (.i_sys_clk(clk), .i_reset_n(rst_n), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .bank(link.bank), .addr(link.addr), .reset_n(link.reset_n),
    .rd_data(link.rd_data), .rd_valid(link.rd_valid));
  always #20 clk = ~clk;
  // one register bus write, strobe high for exactly one edge
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic tk;
    @(posedge clk);
    #1;
  endtask
  // fill a shadow, send its mode-register-set, wait until the device holds it
  task automatic prog(input logic [1:0] a, input logic [15:0] d);
    wr(a, d);
    wr(2'h3, {15'h0, a[0]});
    repeat (3) @(posedge clk);
    tk;
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // one read command; the answer stands only in the next cycle
  task automatic rdcmd(input logic [7:0] e);
    @(posedge clk);
    rdc <= 1'b1;
    @(posedge clk);
    rdc <= 1'b0;
    #1 `CHK(link.rd_valid, 1'b1)
    `CHK(link.rd_data, e)
  endtask
  // cycles between two refresh ticks, synced on a first tick
  task automatic period(input int e);
    do tk; while (tick !== 1'b1);
    n = 0;
    do begin tk; n++; end while (tick !== 1'b1);
    `CHK(n, e)
  endtask
  task automatic close_out;
    $display("compared %0d, mismatched %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h1, 16'h0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      al <= k[2:0];
      burst <= 1'b1;
      prog(2'h0, 16'(k * 9 + (k % 4) * 512 + (k % 2) * 128) + 16'h1900);
      `CHK(write_column_latency, 4'(k + 5))
      `CHK(wl, 5'(2 * k + 5))
      `CHK(partial_array_self_refresh, 3'(k))
      `CHK(rate, k % 2 ? SR_RATE_2X : SR_RATE_1X)
      `CHK(rtt, 2'(k % 4))
    end
    wlev <= 1'b1;
    tk;
    `CHK(rtt, RTTWR_OFF)
    `CHK(nom, 1'b1)
    wlev <= 1'b0;
    burst <= 1'b0;
    sref <= 1'b1;
    tk;
    `CHK(rtt, RTTWR_OFF)
    `CHK(lost, 1'b1)
    burst <= 1'b1;
    dll <= 1'b1;
    prog(2'h0, 16'h0600);
    `CHK(rtt, RTTWR_OFF)
    `CHK(lost, 1'b0)
    $display("latency tests done");
    hot <= 1'b1;
    tk;
    `CHK(sren, 1'b0)
    prog(2'h0, 16'h0000);
    `CHK(rate, SR_RATE_2X)
    `CHK(sren, 1'b1)
    period(REFI_EXT_CYC);
    hot <= 1'b0;
    period(REFI_NORM_CYC);
    $display("refresh tests done");
    prog(2'h1, 16'h0007);
    `CHK(cal, 1'b0)
    idle <= 1'b1;
    prog(2'h1, 16'hfff7);
    `CHK(cal, 1'b1)
    `CHK(loc, 2'h3)
    `CHK(nrd, 1'b0)
    `CHK(sren, 1'b0)
    `CHK(write_column_latency, 4'h5)
    rdcmd(CAL_PATTERN);
    rd(2'h2, {CAL_PATTERN, 8'h02});
    drst <= 1'b1;
    tk;
    drst <= 1'b0;
    tk;
    `CHK(cal, 1'b0)
    prog(2'h1, 16'h0007);
    prog(2'h1, 16'h0003);
    `CHK(loc, 2'h0)
    rdcmd(8'ha3);
    $display("pattern tests done");
    close_out;
  end
  // cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    close_out;
  end
endmodule

//--- tb/mode_reg_props.sv
// assertions watching the mode register command link
module mode_reg_props
  import mode_reg_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_reset_n,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic              reset_n,
  input wire logic [7:0]        rd_data,
  input wire logic              rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic cal_q;
  wire  mrs = !cs_n && !ras_n && !cas_n && !we_n;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  // pattern enable as the device should hold it, cleared by either reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n)
      cal_q <= 1'b0;
    else if (!reset_n)
      cal_q <= 1'b0;
    else if (mrs && bank == BANK_CAL_REG)
      cal_q <= addr[CAL_EN_BIT];
  end
  a_mrs_all_low: assert property (!cs_n |-> !ras_n && !cas_n && !we_n) else $error("partial command");
  a_mrs_bank_one: assert property (mrs |-> bank[1]) else $error("bank bit one low");
  a_mrs_bank_two: assert property (mrs |-> !bank[2]) else $error("bank bit two high");
  a_wl_reserved_zero: assert property (mrs && bank == BANK_WL_REG |-> (addr & ~WL_REG_KEEP) == '0)
    else $error("latency reserved bits set");
  a_cal_reserved_zero: assert property (mrs && bank == BANK_CAL_REG |-> (addr & ~CAL_REG_KEEP) == '0)
    else $error("pattern reserved bits set");
  a_mrs_single_cycle: assert property (mrs |=> cs_n[*2]) else $error("command too long");
  a_pattern_read_data: assert property (rd_valid && $past(cal_q) |-> rd_data == CAL_PATTERN)
    else $error("pattern read wrong");
  a_reset_read_quiet: assert property (!reset_n |=> !rd_valid) else $error("read during reset");
  c_wl_mrs: cover property (mrs && bank == BANK_WL_REG);
  c_cal_mrs: cover property (mrs && bank == BANK_CAL_REG && addr[CAL_EN_BIT]);
  c_pat_read: cover property (rd_valid && cal_q);
endmodule
